// file: src/smp_pkg.sv
package smp_pkg;

	// register byte offsets on the AXI4-Lite slave
	localparam logic [4:0] MAP_CTRL_OFS   = 5'h00;
	localparam logic [4:0] PAGE_CTRL_OFS  = 5'h04;
	localparam logic [4:0] KEY_OFS        = 5'h08;
	localparam logic [4:0] PROT_BITS_OFS  = 5'h0C;
	localparam logic [4:0] PROT_STAT_OFS  = 5'h10;
	localparam int         OFS_W          = 5;

	// map control fields
	localparam int         MAP_SEL_POS    = 0;
	localparam int         MAP_KEEP_POS   = 2;
	localparam logic       MAP_SEL_RST    = 1'b0;
	localparam logic       MAP_KEEP_RST   = 1'b1;

	// page control fields
	localparam int         PAGE_LSB       = 0;
	localparam int         PAGE_W         = 3;
	localparam int         STORE_LSB      = 4;
	localparam int         STORE_W        = 2;
	localparam int         OPER_LSB       = 6;
	localparam int         OPER_W         = 2;
	localparam int         SLOT_CNT       = 4;
	localparam logic [2:0] PAGE_RST       = 3'h0;
	localparam logic [1:0] OPER_SAVE      = 2'h2;
	localparam logic [1:0] OPER_RESTORE   = 2'h3;

	// protection key register fields
	localparam int         MODE_LSB       = 0;
	localparam int         MODE_W         = 2;
	localparam int         LOCKED_POS     = 2;
	localparam int         PASS_LSB       = 3;
	localparam int         PASS_W         = 5;
	localparam logic [1:0] MODE_RST       = 2'h3;
	localparam logic [1:0] MODE_OFF       = 2'h0;
	localparam logic [1:0] MODE_ON        = 2'h3;
	localparam logic [4:0] PASS_MODE_EN   = 5'h18;
	localparam logic [4:0] PASS_OPEN      = 5'h13;
	localparam logic [4:0] PASS_CLOSE     = 5'h15;

	// protected bits register fields
	localparam int         MULT_LSB       = 0;
	localparam int         WDOG_POS       = 4;
	localparam int         PDOWN_POS      = 5;
	localparam int         SLOW_POS       = 6;
	localparam logic [3:0] MULT_RST       = 4'h0;

	// open window, counted in core clock cycles
	localparam int         OPEN_WIN_CORE_CLOCK  = 32;
	localparam int         WIN_CNT_W      = $clog2(OPEN_WIN_CORE_CLOCK + 1);

	localparam logic [1:0] RESP_OKAY      = 2'h0;
	localparam logic [1:0] RESP_SLVERR    = 2'h2;

endpackage : smp_pkg

// file: src/smp_sfr_ctrl.sv
// Functional notes
// - map select bit picks standard or mapped area
// - map select holds until software changes it
// - map control bit 2 reads last written value
// - map control bits 1, 7:3 read zero
// - page field selects paged module decode page
// - page write sets page; read returns active
// - storage select picks slot; write-only field
// - operation 0X loads page directly
// - operation 10 saves old page, loads new
// - operation 11 restores page from slot
// - protected bits refuse writes while locked
// - open key opens access when scheme field is 11
// - close key closes access at once when scheme field is 11
// - open access closes after 32 cycles
// - open key again restarts the count
// - protected: multiplier, watchdog, power, slow-down
// - scheme field changes only with mode key
// - key register bit 2 shows lock state
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
module smp_sfr_ctrl #(
	parameter int ADDR_W = 8,
	parameter int MULT_W = 4
) (
	input  wire logic                       clk_sys,
	input  wire logic                       arst_n,
	input  wire logic [ADDR_W-1:0]          s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [ADDR_W-1:0]          s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	output logic                            mapSelect,
	output logic [smp_pkg::PAGE_W-1:0]      pageSelect,
	output logic [MULT_W-1:0]               clockMultiplierFactor,
	output logic                            watchdogEnableBit,
	output logic                            powerDownBit,
	output logic                            slowDownBit,
	output logic                            protectLocked
);
	import smp_pkg::*;

	// the decode needs every offset bit; the multiplier field has 4 bits
	if (ADDR_W < OFS_W || MULT_W < 1 || MULT_W > 4) begin : gBadParam
		$error("smp_sfr_ctrl: unsupported ADDR_W or MULT_W");
	end

	localparam logic [WIN_CNT_W-1:0] WIN_LOAD = WIN_CNT_W'(OPEN_WIN_CORE_CLOCK);

	// valid register offset: aligned word, upper address bits zero
	function automatic logic addrHit(input logic [ADDR_W-1:0] a,
			input logic [4:0] ofs);
		addrHit = (a == ADDR_W'(ofs));
	endfunction : addrHit

	function automatic logic addrMapped(input logic [ADDR_W-1:0] a);
		addrMapped = addrHit(a, MAP_CTRL_OFS) || addrHit(a, PAGE_CTRL_OFS)
			|| addrHit(a, KEY_OFS) || addrHit(a, PROT_BITS_OFS)
			|| addrHit(a, PROT_STAT_OFS);
	endfunction : addrMapped

	// ---------------- AXI4-Lite write path ----------------
	logic [ADDR_W-1:0]          awAddr_q;
	logic                       awHeld_q;
	logic [7:0]                 wByte_q;
	logic                       wLane0_q;
	logic                       wHeld_q;
	logic                       bValid_q;
	logic [1:0]                 bResp_q;
	logic                       doWrite;
	logic                       wrEn;
	logic                       wrHit;

	assign s_axi_awready = !awHeld_q;
	assign s_axi_wready  = !wHeld_q;
	assign s_axi_bvalid  = bValid_q;
	assign s_axi_bresp   = bResp_q;
	// address and data may arrive in either order; commit once both held
	assign doWrite = awHeld_q && wHeld_q && !bValid_q;
	// only byte lane 0 carries register bits; other lanes are ignored
	assign wrEn    = doWrite && wLane0_q;
	// unmapped offsets answer SLVERR and change no register
	assign wrHit   = addrMapped(awAddr_q);

	// one write in flight: awready stays low until the commit
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			awHeld_q <= 1'b0;
			awAddr_q <= '0;
		end else if (s_axi_awvalid && !awHeld_q) begin
			awHeld_q <= 1'b1;
			awAddr_q <= s_axi_awaddr;
		end else if (doWrite) begin
			awHeld_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wHeld_q  <= 1'b0;
			wByte_q  <= 8'h00;
			wLane0_q <= 1'b0;
		end else if (s_axi_wvalid && !wHeld_q) begin
			wHeld_q  <= 1'b1;
			wByte_q  <= s_axi_wdata[7:0];
			wLane0_q <= s_axi_wstrb[0];
		end else if (doWrite) begin
			wHeld_q  <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			bValid_q <= 1'b0;
			bResp_q  <= RESP_OKAY;
		end else if (doWrite) begin
			bValid_q <= 1'b1;
			bResp_q  <= wrHit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bValid_q <= 1'b0;
		end
	end

	logic wrMap;
	logic wrPage;
	logic wrKey;
	logic wrProt;

	assign wrMap  = wrEn && addrHit(awAddr_q, MAP_CTRL_OFS);
	assign wrPage = wrEn && addrHit(awAddr_q, PAGE_CTRL_OFS);
	assign wrKey  = wrEn && addrHit(awAddr_q, KEY_OFS);
	assign wrProt = wrEn && addrHit(awAddr_q, PROT_BITS_OFS);

	// ---------------- map control ----------------
	logic mapSel_q;
	logic mapKeep_q;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			mapSel_q  <= MAP_SEL_RST;
			mapKeep_q <= MAP_KEEP_RST;
		end else if (wrMap) begin
			mapSel_q  <= wByte_q[MAP_SEL_POS];
			mapKeep_q <= wByte_q[MAP_KEEP_POS];
		end
	end

	assign mapSelect = mapSel_q;

	// ---------------- page control ----------------
	logic [PAGE_W-1:0] page_q;
	logic [PAGE_W-1:0] page_d;
	logic [PAGE_W-1:0] slot_q [SLOT_CNT];
	logic [OPER_W-1:0] wrOper;
	logic [STORE_W-1:0] wrSlot;
	logic [PAGE_W-1:0] wrPageVal;
	logic              saveOp;

	assign wrOper    = wByte_q[OPER_LSB +: OPER_W];
	assign wrSlot    = wByte_q[STORE_LSB +: STORE_W];
	assign wrPageVal = wByte_q[PAGE_LSB +: PAGE_W];
	assign saveOp    = wrPage && (wrOper == OPER_SAVE);

	always_comb begin
		page_d = page_q;
		if (wrPage) begin
			if (wrOper == OPER_RESTORE) begin
				page_d = slot_q[wrSlot];
			end else begin
				page_d = wrPageVal;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			page_q <= PAGE_RST;
		end else begin
			page_q <= page_d;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < SLOT_CNT; i++) begin
				slot_q[i] <= '0;
			end
		end else if (saveOp) begin
			// page_q is still the page from before this write
			// slot by select
			slot_q[wrSlot] <= page_q;
		end
	end

	assign pageSelect = page_q;

	// ---------------- protection scheme ----------------
	logic [MODE_W-1:0]    mode_q;
	logic [WIN_CNT_W-1:0] winCnt_q;
	logic [PASS_W-1:0]    wrPass;
	logic                 schemeOn;
	logic                 accessOpen;
	logic                 keyMode;
	logic                 keyOpen;
	logic                 keyClose;

	assign wrPass     = wByte_q[PASS_LSB +: PASS_W];
	// any value other than 00 keeps the scheme active
	assign schemeOn   = (mode_q != MODE_OFF);
	assign accessOpen = (winCnt_q != '0);
	assign protectLocked = schemeOn && !accessOpen;

	// the mode key works in every mode; open and close only in mode 11
	assign keyMode  = wrKey && (wrPass == PASS_MODE_EN);
	assign keyOpen  = wrKey && (mode_q == MODE_ON) && (wrPass == PASS_OPEN);
	assign keyClose = wrKey && (mode_q == MODE_ON) && (wrPass == PASS_CLOSE);

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			mode_q <= MODE_RST;
		end else if (keyMode) begin
			mode_q <= wByte_q[MODE_LSB +: MODE_W];
		end
	end

	// open and close keys act only while the scheme field is exactly 11
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			winCnt_q <= '0;
		end else if (keyOpen) begin
			winCnt_q <= WIN_LOAD;
		end else if (keyClose) begin
			winCnt_q <= '0;
		end else if (accessOpen) begin
			winCnt_q <= winCnt_q - WIN_CNT_W'(1);
		end
	end

	// ---------------- protected bits ----------------
	logic [MULT_W-1:0] mult_q;
	logic              wdog_q;
	logic              pdown_q;
	logic              slow_q;

	// a dropped write still answers OKAY; software checks the lock bit
	// locked writes dropped
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			mult_q  <= MULT_W'(MULT_RST);
			wdog_q  <= 1'b0;
			pdown_q <= 1'b0;
			slow_q  <= 1'b0;
		end else if (wrProt && !protectLocked) begin
			mult_q  <= wByte_q[MULT_LSB +: MULT_W];
			wdog_q  <= wByte_q[WDOG_POS];
			pdown_q <= wByte_q[PDOWN_POS];
			slow_q  <= wByte_q[SLOW_POS];
		end
	end

	assign clockMultiplierFactor = mult_q;
	assign watchdogEnableBit     = wdog_q;
	assign powerDownBit          = pdown_q;
	assign slowDownBit           = slow_q;

	// ---------------- AXI4-Lite read path ----------------
	logic        rValid_q;
	logic [31:0] rData_q;
	logic [1:0]  rResp_q;
	logic [7:0]  rdByte;
	logic        rdHit;

	assign s_axi_arready = !rValid_q;
	assign s_axi_rvalid  = rValid_q;
	assign s_axi_rdata   = rData_q;
	assign s_axi_rresp   = rResp_q;
	assign rdHit         = addrMapped(s_axi_araddr);

	always_comb begin
		rdByte = 8'h00;
		if (addrHit(s_axi_araddr, MAP_CTRL_OFS)) begin
			rdByte[MAP_SEL_POS]  = mapSel_q;
			rdByte[MAP_KEEP_POS] = mapKeep_q;
		end else if (addrHit(s_axi_araddr, PAGE_CTRL_OFS)) begin
			// bit 3 zero; select and operation write-only
			rdByte[PAGE_LSB +: PAGE_W] = page_q;
		end else if (addrHit(s_axi_araddr, KEY_OFS)) begin
			rdByte[MODE_LSB +: MODE_W] = mode_q;
			rdByte[LOCKED_POS]         = protectLocked;
		end else if (addrHit(s_axi_araddr, PROT_BITS_OFS)) begin
			rdByte[MULT_LSB +: MULT_W] = mult_q;
			rdByte[WDOG_POS]           = wdog_q;
			rdByte[PDOWN_POS]          = pdown_q;
			rdByte[SLOW_POS]           = slow_q;
		end else if (addrHit(s_axi_araddr, PROT_STAT_OFS)) begin
			// remaining open cycles, for software polling the window
			rdByte = 8'(winCnt_q);
		end
	end

	// image taken at accept; a write committing on that edge is not seen
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rValid_q <= 1'b0;
			rData_q  <= 32'h0000_0000;
			rResp_q  <= RESP_OKAY;
		end else if (s_axi_arvalid && !rValid_q) begin
			rValid_q <= 1'b1;
			rData_q  <= {24'h00_0000, rdByte};
			rResp_q  <= rdHit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			rValid_q <= 1'b0;
		end
	end

endmodule : smp_sfr_ctrl

// file: bench/smp_sfr_checker.sv
`timescale 1ns/10ps
module smp_sfr_checker (
	input wire logic                   clk_sys,
	input wire logic                   arst_n,
	input wire logic                   s_axi_bvalid,
	input wire logic                   s_axi_arvalid,
	input wire logic                   s_axi_arready,
	input wire logic                   s_axi_rvalid,
	input wire logic                   s_axi_rready,
	input wire logic [31:0]            s_axi_rdata,
	input wire logic                   mapSelect,
	input wire logic [smp_pkg::PAGE_W-1:0] pageSelect,
	input wire logic                   watchdogEnableBit,
	input wire logic                   protectLocked
);
	import smp_pkg::*;
	logic [5:0] lowCnt_q;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	// any write commit may reload the window, so restart there
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) lowCnt_q <= 6'h0;
		else if (protectLocked || $rose(s_axi_bvalid)) lowCnt_q <= 6'h0;
		else lowCnt_q <= lowCnt_q + 6'h1;
	end
	property p_mapHold; !$stable(mapSelect) |-> $rose(s_axi_bvalid); endproperty
	a_mapHold: assert property (p_mapHold) else $error("map moved");
	property p_pageHold; !$stable(pageSelect) |-> $rose(s_axi_bvalid); endproperty
	a_pageHold: assert property (p_pageHold) else $error("page moved");
	property p_protWr;
		!$stable(watchdogEnableBit) |-> !$past(protectLocked) && $rose(s_axi_bvalid);
	endproperty
	a_protWr: assert property (p_protWr) else $error("locked bit");
	property p_openWr; $fell(protectLocked) |-> $rose(s_axi_bvalid); endproperty
	a_openWr: assert property (p_openWr) else $error("bad open");
	property p_winMax; lowCnt_q < 6'h20; endproperty
	a_winMax: assert property (p_winMax) else $error("window long");
	property p_rdZero; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
	a_rdZero: assert property (p_rdZero) else $error("high bits");
	property p_rdAns; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rdAns: assert property (p_rdAns) else $error("no read data");
	property p_rdHold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rdHold: assert property (p_rdHold) else $error("read data moved");
	c_open: cover property ($fell(protectLocked));
	c_map: cover property ($rose(mapSelect));
	c_page: cover property ($changed(pageSelect));
endmodule : smp_sfr_checker
bind smp_sfr_ctrl smp_sfr_checker u_chk (.*);

// file: bench/smp_cpu_model.sv
`timescale 1ns/10ps
module smp_cpu_model (
	input  wire logic        clk_sys,
	output logic [7:0]       s_axi_awaddr,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic [31:0]      s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	output logic [7:0]       s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready
);
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hF;
	end
	// handshakes sampled at the falling edge, where comb readies are settled
	task automatic wr(input logic [4:0] a, input logic [31:0] v,
		output logic [1:0] r);
		logic aw, w, b;
		@(posedge clk_sys);
		s_axi_awaddr <= {3'h0, a};
		s_axi_wdata <= v;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(negedge clk_sys);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clk_sys);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end while (!b);
		s_axi_bready <= 1'b0;
		s_axi_wdata <= ~v;
	endtask : wr
	task automatic rd(input logic [4:0] a, output logic [31:0] v,
		output logic [1:0] r);
		logic ar, ok;
		@(posedge clk_sys);
		s_axi_araddr <= {3'h0, a};
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(negedge clk_sys);
			ar = s_axi_arvalid && s_axi_arready;
			ok = s_axi_rvalid;
			v = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk_sys);
			if (ar) s_axi_arvalid <= 1'b0;
		end while (!ok);
		s_axi_rready <= 1'b0;
	endtask : rd
endmodule : smp_cpu_model

// file: bench/tb.sv
`timescale 1ns/10ps
module tb;
	import smp_pkg::*;
	logic        clk_sys, arst_n, mapSelect, protectLocked;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb, clockMultiplierFactor;
	logic [2:0]  pageSelect;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic        watchdogEnableBit, powerDownBit, slowDownBit;
	int          nFail, totalChecks, s;
	smp_sfr_ctrl u_dut (.*);
	smp_cpu_model u_cpu (.*);
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	task automatic chk(input string n, input logic [31:0] e, g);
		totalChecks++;
		if (g !== e) begin
			nFail++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic rchk(input logic [4:0] a, input logic [31:0] e);
		u_cpu.rd(a, d, r);
		chk("rdata", e, d);
		chk("rresp", 32'(RESP_OKAY), r);
	endtask : rchk
	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		u_cpu.wr(a, {24'h0, v}, r);
		chk("bresp", 32'(RESP_OKAY), r);
	endtask : wr
	task automatic finishTest;
		$display("checks %0d mismatches %0d", totalChecks, nFail);
		if (nFail == 0 && totalChecks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : finishTest
	initial begin
		repeat (5000) @(posedge clk_sys);
		nFail++;
		finishTest();
	end
	initial begin
		arst_n = 1'b0;
		repeat (8) @(posedge clk_sys);
		arst_n <= 1'b1;
		chk("lock", 32'h1, protectLocked);
		rchk(MAP_CTRL_OFS, 32'h0000_0004);
		chk("map", 32'h0, mapSelect);
		rchk(KEY_OFS, 32'h0000_0007);
		wr(PAGE_CTRL_OFS, 8'hC7);
		rchk(PAGE_CTRL_OFS, 32'h0);
		u_cpu.rd(MAP_CTRL_OFS, d, r);
		wr(MAP_CTRL_OFS, d[7:0] | 8'h01);
		chk("map", 32'h1, mapSelect);
		rchk(MAP_CTRL_OFS, 32'h0000_0005);
		$display("map test done");
		wr(PAGE_CTRL_OFS, 8'h0D);
		rchk(PAGE_CTRL_OFS, 32'h0000_0005);
		chk("page", 32'h5, pageSelect);
		for (s = 0; s < 4; s++) wr(PAGE_CTRL_OFS, 8'(8'h81 + s * 17));
		chk("page", 32'h4, pageSelect);
		for (s = 0; s < 4; s++) begin
			wr(PAGE_CTRL_OFS, 8'(8'hC7 + s * 16));
			chk("slot", s ? s : 5, pageSelect);
		end
		wr(PAGE_CTRL_OFS, 8'h76);
		rchk(PAGE_CTRL_OFS, 32'h0000_0006);
		chk("map", 32'h1, mapSelect);
		wr(MAP_CTRL_OFS, 8'hFA);
		rchk(MAP_CTRL_OFS, 32'h0);
		$display("page test done");
		wr(PROT_BITS_OFS, 8'h7F);
		rchk(PROT_BITS_OFS, 32'h0);
		wr(KEY_OFS, 8'h9B);
		rchk(KEY_OFS, 32'h0000_0003);
		wr(PROT_BITS_OFS, 8'h7F);
		chk("prot", 32'h7F, {slowDownBit, powerDownBit, watchdogEnableBit,
			clockMultiplierFactor});
		wr(KEY_OFS, 8'hAB);
		rchk(KEY_OFS, 32'h0000_0007);
		rchk(PROT_STAT_OFS, 32'h0);
		wr(PROT_BITS_OFS, 8'h00);
		rchk(PROT_BITS_OFS, 32'h0000_007F);
		wr(KEY_OFS, 8'h9B);
		repeat (20) @(posedge clk_sys);
		wr(KEY_OFS, 8'h9B);
		repeat (20) @(posedge clk_sys);
		chk("open", 32'h0, protectLocked);
		u_cpu.rd(PROT_STAT_OFS, d, r);
		chk("stat", 32'h1, 32'(d > 0 && d <= OPEN_WIN_CORE_CLOCK));
		repeat (20) @(posedge clk_sys);
		chk("lock", 32'h1, protectLocked);
		wr(KEY_OFS, 8'hC0);
		rchk(KEY_OFS, 32'h0);
		wr(KEY_OFS, 8'h03);
		rchk(KEY_OFS, 32'h0);
		wr(PROT_BITS_OFS, 8'h00);
		rchk(PROT_BITS_OFS, 32'h0);
		wr(KEY_OFS, 8'hC1);
		rchk(KEY_OFS, 32'h0000_0005);
		wr(KEY_OFS, 8'h9B);
		rchk(KEY_OFS, 32'h0000_0005);
		wr(PROT_BITS_OFS, 8'h7F);
		rchk(PROT_BITS_OFS, 32'h0);
		wr(KEY_OFS, 8'hC3);
		rchk(KEY_OFS, 32'h0000_0007);
		u_cpu.wr(5'h14, 32'h0000_00FF, r);
		chk("bresp", 32'(RESP_SLVERR), r);
		u_cpu.rd(5'h14, d, r);
		chk("rresp", 32'(RESP_SLVERR), r);
		$display("protect test done");
		finishTest();
	end
endmodule : tb
